// ===== lcc_top.sv
// Operation
// RL1: cell logic keeps evaluating whenever its selected sources toggle, not only on cpu activity.
// RL2: enabled cell with fast oscillator selected keeps that oscillator running in sleep.
// RL3: software clears the enable before changing inputs, gates, polarity or function.
// RL4: software then picks inputs, pin directions, gate routing, polarities, function, inversion.
// RL5: to drive a pin, software routes it to the cell output and makes it output.
// RL6: for interrupts software sets edge enables, cell, peripheral and global irq enables.
// RL7: setting the enable bit is the last setup step.
// RL8: enable bit 7 set lets the cell combine inputs; clear forces output zero.
// RL9: bit 5 is read-only, mirrors the inverted cell output, resets to zero; the code mirrors the synchronised output without inversion.
// RL10: bit 4 rise enable, bit 3 fall enable, bits 2:0 function; read/write, reset zero.
// RL11: function select picks which logic function combines the four gate outputs.
// RL12: codes 111 latch, 110 jk, 101 dff2, 100 dff, 011 sr, 001 or-xor.
// RL13: irq flag sets on rising edge with rise enable, falling edge with fall enable.
// RL14: control bit 6 reads zero and ignores writes.
`timescale 1ns/1ps
module lcc_top
  import lcc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // cell links
  input  wire logic [3:0]  gate_out,
  input  wire logic        cell_output,
  input  wire logic        fast_osc_selected,
  output logic             logic_result,
  output logic             fast_osc_keep_on,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage two is read, and out_prev_ff, one cycle behind it, is read for edge detection
  logic [3:0] gate_s1_ff, gate_s2_ff;
  logic       out_s1_ff, out_s2_ff, out_prev_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_s1_ff  <= 4'h0;
      gate_s2_ff  <= 4'h0;
      out_s1_ff   <= 1'b0;
      out_s2_ff   <= 1'b0;
      out_prev_ff <= 1'b0;
    end else begin
      gate_s1_ff  <= gate_out;
      gate_s2_ff  <= gate_s1_ff;
      out_s1_ff   <= cell_output;
      out_s2_ff   <= out_s1_ff;
      out_prev_ff <= out_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  logic [7:0] ctrl_ff;
  logic       flag_ff, irq_en_ff;
  logic       aw_held_ff, w_held_ff;
  logic [3:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic       wstrb0_ff;
  wire do_write  = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 4'h0;
      wdata_ff   <= 8'h00;
      wstrb0_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end
  wire wr_byte   = do_write & wstrb0_ff;
  wire wr_ctrl   = wr_byte & (awaddr_ff == CELL_CONTROL_OFS);
  wire wr_flag   = wr_byte & (awaddr_ff == CELL_IRQ_FLAG_OFS);
  wire wr_irq_en = wr_byte & (awaddr_ff == CELL_IRQ_EN_OFS);
  wire wr_mapped = (awaddr_ff == CELL_CONTROL_OFS) | (awaddr_ff == CELL_IRQ_FLAG_OFS) |
                   (awaddr_ff == CELL_IRQ_EN_OFS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_ff & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_ff & ~(s_axi_wvalid & s_axi_wready);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and events
  wire rise_evt = out_s2_ff & ~out_prev_ff & ctrl_ff[RISE_BIT]; // RL13
  wire fall_evt = ~out_s2_ff & out_prev_ff & ctrl_ff[FALL_BIT]; // RL13
  // bit 5 mirrors the synchronised output; bit 6 never stores
  wire [7:0] ctrl_rd = {ctrl_ff[EN_BIT], 1'b0, out_s2_ff, ctrl_ff[RISE_BIT:0]}; // RL9 RL14
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff   <= CTRL_RESET; // RL10
      flag_ff   <= 1'b0;
      irq_en_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wdata_ff & CTRL_WMASK; // RL10 RL14
      end
      // a new edge wins over a simultaneous write-one clear
      flag_ff <= (rise_evt | fall_evt) | (flag_ff & ~(wr_flag & wdata_ff[IRQ_FLAG_BIT])); // RL13
      if (wr_irq_en) begin
        irq_en_ff <= wdata_ff[IRQ_FLAG_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  wire [31:0] rd_mux = (s_axi_araddr == CELL_CONTROL_OFS)  ? {24'h00_0000, ctrl_rd} :
                       (s_axi_araddr == CELL_IRQ_FLAG_OFS) ? {31'h0000_0000, flag_ff} :
                       (s_axi_araddr == CELL_IRQ_EN_OFS)   ? {31'h0000_0000, irq_en_ff} :
                       32'h0000_0000;
  wire rd_mapped = (s_axi_araddr == CELL_CONTROL_OFS) | (s_axi_araddr == CELL_IRQ_FLAG_OFS) |
                   (s_axi_araddr == CELL_IRQ_EN_OFS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux; // RL9
        s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // logic function and outputs
  lcc_func_if fif ();
  assign fif.gate   = gate_s2_ff;
  assign fif.mode   = lcc_mode_t'(ctrl_ff[MODE_MSB:0]); // RL11
  assign fif.enable = ctrl_ff[EN_BIT]; // RL8
  lcc_func u_func (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fif     (fif.fn)
  );
  // the cell still samples on aclk, so in sleep aclk must be kept alive too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      logic_result     <= 1'b0;
      fast_osc_keep_on <= 1'b0;
      irq              <= 1'b0;
    end else begin
      logic_result     <= fif.result; // RL1 RL8
      fast_osc_keep_on <= ctrl_ff[EN_BIT] & fast_osc_selected; // RL2
      irq              <= flag_ff & irq_en_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_disabled_zero;
    !ctrl_ff[EN_BIT] ##1 !ctrl_ff[EN_BIT] |=> !logic_result;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("disabled cell output not zero"); // RL8

  property p_mirror;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CELL_CONTROL_OFS
      |=> s_axi_rdata[OUT_BIT] == $past(out_s2_ff) && !s_axi_rdata[UNUSED_BIT];
  endproperty
  a_mirror: assert property (p_mirror) else $error("output mirror or bit 6 wrong"); // RL9

  property p_bit6_zero;
    ctrl_ff[UNUSED_BIT] == 1'b0 && ctrl_ff[OUT_BIT] == 1'b0;
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("read-only control bits stored"); // RL14

  property p_ctrl_write;
    wr_ctrl |=> ctrl_ff[RISE_BIT:0] == $past(wdata_ff[RISE_BIT:0]) && ctrl_ff[EN_BIT] == $past(wdata_ff[EN_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored"); // RL10

  property p_rise_flag;
    ctrl_ff[RISE_BIT] && out_s2_ff && !out_prev_ff |=> flag_ff ##1 irq == $past(irq_en_ff);
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge missed"); // RL13

  property p_fall_flag;
    ctrl_ff[FALL_BIT] && !out_s2_ff && out_prev_ff |=> flag_ff;
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("falling edge missed"); // RL13

  property p_no_edge_no_flag;
    !flag_ff && !rise_evt && !fall_evt |=> !flag_ff;
  endproperty
  a_no_edge_no_flag: assert property (p_no_edge_no_flag) else $error("flag set without edge"); // RL13

  property p_osc_keep;
    ctrl_ff[EN_BIT] && fast_osc_selected |=> fast_osc_keep_on;
  endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("fast oscillator released"); // RL2
endmodule : lcc_top

// ===== lcc_pkg.sv
package lcc_pkg;
  // register byte offsets
  localparam logic [3:0] CELL_CONTROL_OFS  = 4'h0;
  localparam logic [3:0] CELL_IRQ_FLAG_OFS = 4'h4;
  localparam logic [3:0] CELL_IRQ_EN_OFS   = 4'h8;
  // cell_control_reg fields
  localparam int EN_BIT      = 7;
  localparam int UNUSED_BIT  = 6;
  localparam int OUT_BIT     = 5;
  localparam int RISE_BIT    = 4;
  localparam int FALL_BIT    = 3;
  localparam int MODE_MSB    = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h9F;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int SYNC_STAGES  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    MODE_AND_OR  = 3'h0,
    MODE_OR_XOR  = 3'h1,
    MODE_AND4    = 3'h2,
    MODE_SR      = 3'h3,
    MODE_DFF_SR  = 3'h4,
    MODE_DFF2_R  = 3'h5,
    MODE_JK_R    = 3'h6,
    MODE_LATCH   = 3'h7
  } lcc_mode_t;
endpackage : lcc_pkg

// ===== lcc_func_if.sv
`timescale 1ns/1ps
interface lcc_func_if;
  import lcc_pkg::*;
  logic [3:0] gate;
  lcc_mode_t  mode;
  logic       enable;
  logic       result;
  modport ctl (output gate, output mode, output enable, input result);
  modport fn  (input gate, input mode, input enable, output result);
endinterface : lcc_func_if

// ===== lcc_func.sv
`timescale 1ns/1ps
module lcc_func
  import lcc_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // function port
  lcc_func_if.fn    fif
);
  logic q_ff, nxt_q;
  logic clk_prev_ff;
  wire g1 = fif.gate[0];
  wire g2 = fif.gate[1];
  wire g3 = fif.gate[2];
  wire g4 = fif.gate[3];
  wire clk_rise = g1 & ~clk_prev_ff;
  wire comb_out = (fif.mode == MODE_AND_OR) ? ((g1 & g2) | (g3 & g4)) :
                  (fif.mode == MODE_OR_XOR) ? ((g1 | g2) ^ (g3 | g4)) :
                  (g1 & g2 & g3 & g4);
  wire seq_mode = fif.mode[2] | (fif.mode == MODE_SR);

  // sequential functions: reset dominates set, set dominates the clocked input
  always_comb begin
    nxt_q = q_ff;
    unique case (fif.mode)
      MODE_SR:     nxt_q = (g3 | g4) ? 1'b0 : ((g1 | g2) ? 1'b1 : q_ff);
      MODE_DFF_SR: nxt_q = g3 ? 1'b0 : (g4 ? 1'b1 : (clk_rise ? g2 : q_ff));
      MODE_DFF2_R: nxt_q = g3 ? 1'b0 : (clk_rise ? (g2 & g4) : q_ff);
      MODE_JK_R:   nxt_q = g3 ? 1'b0 : (clk_rise ? ((g2 & ~q_ff) | (~g4 & q_ff)) : q_ff);
      MODE_LATCH:  nxt_q = g3 ? 1'b0 : (g4 ? 1'b1 : (g1 ? g2 : q_ff));
      default:     nxt_q = q_ff;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !fif.enable) begin // RL8
      q_ff        <= 1'b0;
      clk_prev_ff <= 1'b0;
    end else begin
      q_ff        <= nxt_q; // RL12
      clk_prev_ff <= g1;
    end
  end

  assign fif.result = fif.enable & (seq_mode ? q_ff : comb_out); // RL11

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_func_or_xor;
    fif.enable && fif.mode == MODE_OR_XOR |-> fif.result == ((g1 | g2) ^ (g3 | g4));
  endproperty
  a_func_or_xor: assert property (p_func_or_xor) else $error("or-xor result wrong"); // RL12

  property p_func_jk_reset;
    fif.enable && fif.mode == MODE_JK_R && g3 ##1 fif.enable && fif.mode == MODE_JK_R |-> !fif.result;
  endproperty
  a_func_jk_reset: assert property (p_func_jk_reset) else $error("jk reset not honoured"); // RL12

  property p_func_off;
    !fif.enable |-> !fif.result;
  endproperty
  a_func_off: assert property (p_func_off) else $error("disabled cell not zero"); // RL8
endmodule : lcc_func

// ===== lcc_top_tb.sv
`timescale 1ns/1ps
module lcc_top_tb;
  import lcc_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, gate_out = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        cell_output = 1'b0, fast_osc_selected = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, logic_result, fast_osc_keep_on, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r[$];
  int          n_fail = 0;
  int          n_compared = 0;
  // {mode, gate pattern, expected result}; sequential modes keep state between rows
  logic [7:0]  seq_tab[19] = '{8'h63, 8'h61, 8'h68, 8'h84, 8'h87, 8'h81, 8'h82, 8'h91, 8'hB7, 8'hB5,
                               8'hA6, 8'hC4, 8'hC7, 8'hC1, 8'hC8, 8'hD2, 8'hE7, 8'hE5, 8'hE2};

  lcc_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gate_out(gate_out), .cell_output(cell_output), .fast_osc_selected(fast_osc_selected),
    .logic_result(logic_result), .fast_osc_keep_on(fast_osc_keep_on), .irq(irq)
  );

  always #2 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic give_up();
    n_fail++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report();
  endtask : give_up

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // the response edge is tested first so a released valid is never re-driven in that step
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    exp_b.push_back(er);
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (bvalid) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // one idle edge so the next call never re-drives a strobe in this step
    @(posedge aclk);
    if (n == 50) give_up();
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    exp_r.push_back({er, 24'h00_0000, d});
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (rvalid) break;
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
    if (n == 50) give_up();
  endtask : rd

  task automatic ctl(input logic [7:0] d);
    wr(CELL_CONTROL_OFS, d, 4'hF, RESP_OKAY);
  endtask : ctl

  function automatic logic comb_exp(input logic [2:0] m, input logic [3:0] g);
    case (m)
      3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
      default: return &g;
    endcase
  endfunction : comb_exp

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (bvalid && bready && exp_b.size() > 0)
      check({32'h0000_0000, bresp}, {32'h0000_0000, exp_b.pop_front()});
    if (rvalid && rready && exp_r.size() > 0)
      check({rresp, rdata}, exp_r.pop_front());
  end

  initial begin
    int         i;
    int         j;
    logic [7:0] e;
    logic [2:0] prev_mode;
    void'($urandom(36459));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CELL_CONTROL_OFS, 8'h00, RESP_OKAY);
    rd(CELL_IRQ_FLAG_OFS, 8'h00, RESP_OKAY);
    rd(4'hC, 8'h00, RESP_SLVERR);
    wr(4'hC, 8'hFF, 4'hF, RESP_SLVERR);
    ctl(8'hFF);
    rd(CELL_CONTROL_OFS, 8'h9F, RESP_OKAY);
    wr(CELL_CONTROL_OFS, 8'h00, 4'h0, RESP_OKAY);
    rd(CELL_CONTROL_OFS, 8'h9F, RESP_OKAY);
    $display("test registers done");
    prev_mode = 3'h7;
    for (i = 0; i < 3; i++) begin
      ctl({5'b0_0000, prev_mode});
      ctl({5'b0_0000, i[2:0]});
      ctl({5'b1_0000, i[2:0]});
      prev_mode = i[2:0];
      rd(CELL_CONTROL_OFS, {5'b1_0000, i[2:0]}, RESP_OKAY);
      for (j = 0; j < 4; j++) begin
        gate_out <= 4'($urandom);
        cyc(6);
        check({33'h0_0000_0000, logic_result}, {33'h0_0000_0000, comb_exp(i[2:0], gate_out)});
      end
    end
    ctl(8'h02);
    gate_out <= 4'h1;
    cyc(6);
    check({33'h0_0000_0000, logic_result}, 34'h0_0000_0000);
    fast_osc_selected <= 1'b1;
    cyc(3);
    check({33'h0_0000_0000, fast_osc_keep_on}, 34'h0_0000_0000);
    ctl(8'h82);
    cyc(3);
    check({33'h0_0000_0000, fast_osc_keep_on}, 34'h0_0000_0001);
    fast_osc_selected <= 1'b0;
    cyc(3);
    check({33'h0_0000_0000, fast_osc_keep_on}, 34'h0_0000_0000);
    $display("test combinational and enable done");
    // disable before each function change, enable last, as setup software would
    prev_mode = 3'h2;
    for (i = 0; i < 19; i++) begin
      e = seq_tab[i];
      if (e[7:5] != prev_mode) begin
        gate_out <= 4'h0;
        ctl({5'b0_0000, prev_mode});
        ctl({5'b0_0000, e[7:5]});
        ctl({5'b1_0000, e[7:5]});
        prev_mode = e[7:5];
      end
      gate_out <= e[4:1];
      cyc(6);
      check({33'h0_0000_0000, logic_result}, {33'h0_0000_0000, e[0]});
    end
    $display("test sequential modes done");
    ctl(8'h07);
    ctl(8'h10);
    wr(CELL_IRQ_EN_OFS, 8'h01, 4'hF, RESP_OKAY);
    ctl(8'h90);
    cell_output <= 1'b1;
    cyc(6);
    check({33'h0_0000_0000, irq}, 34'h0_0000_0001);
    rd(CELL_CONTROL_OFS, 8'hB0, RESP_OKAY);
    wr(CELL_IRQ_FLAG_OFS, 8'h01, 4'hF, RESP_OKAY);
    rd(CELL_IRQ_FLAG_OFS, 8'h00, RESP_OKAY);
    cell_output <= 1'b0;
    cyc(6);
    rd(CELL_IRQ_FLAG_OFS, 8'h00, RESP_OKAY);
    ctl(8'h88);
    cell_output <= 1'b1;
    cyc(6);
    rd(CELL_IRQ_FLAG_OFS, 8'h00, RESP_OKAY);
    cell_output <= 1'b0;
    cyc(6);
    rd(CELL_IRQ_FLAG_OFS, 8'h01, RESP_OKAY);
    check({33'h0_0000_0000, irq}, 34'h0_0000_0001);
    wr(CELL_IRQ_EN_OFS, 8'h00, 4'hF, RESP_OKAY);
    cyc(3);
    check({33'h0_0000_0000, irq}, 34'h0_0000_0000);
    rd(CELL_CONTROL_OFS, 8'h88, RESP_OKAY);
    $display("test interrupts done");
    // mid-run reset: control and the pending flag must both return to zero
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rd(CELL_CONTROL_OFS, 8'h00, RESP_OKAY);
    rd(CELL_IRQ_FLAG_OFS, 8'h00, RESP_OKAY);
    check({33'h0_0000_0000, irq}, 34'h0_0000_0000);
    $display("test reset done");
    cyc(4);
    final_report();
  end
endmodule : lcc_top_tb
